// *** link_pkg.sv ***
// Constants, register layout and link timing shared by both link ends.
// Assumes a 20 MHz MCLK and APB software access on the initiator end.
package link_pkg;
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_FAULT     = 8'h04;
   localparam logic [7:0] OFS_IRQ_BUSY  = 8'h08;
   localparam logic [7:0] OFS_ADDRESS   = 8'h0C;
   localparam logic [7:0] OFS_REQUEST   = 8'h10;
   localparam logic [7:0] OFS_MODE      = 8'h14;
   localparam int BIT_IRQ_EN    = 7;
   localparam int BIT_SUMMARY   = 7;
   localparam int BIT_ACK_LEVEL = 6;
   localparam int BIT_CANCEL    = 5;
   localparam int BIT_TIMEOUT   = 4;
   localparam int BIT_TARGET    = 3;
   localparam int BIT_PARITY    = 2;
   localparam int BIT_EXT_FLAG  = 7;
   localparam int BIT_BUSY      = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] FAULT_RESET   = 8'h00;
   localparam logic [3:0] WAIT_RESET    = 4'h0;
   localparam logic [3:0] CLK_DIV_HALF  = 4'h4;
   localparam int FRAME_BITS    = 16;
   localparam logic [7:0] CMD_IDLE      = 8'h00;
   localparam logic [7:0] CMD_TRANSFER  = 8'hA5;
endpackage

// *** link_if.sv ***
// Interface joining the initiator and target ends of the die link.
// Assumes both ends run from their own MCLK and sample the link lines.
`timescale 1ns/1ps
`default_nettype none
interface link_if;
   logic       link_clock;
   logic       link_data;
   logic [7:0] ack_data;
   logic       ack_error;
   logic [1:0] ack_parity;
   logic       ack_parity_bad;
   logic       ack_valid;
   logic       ext_irq_pin;
   modport initiator (output link_clock, output link_data,
                      input ack_data, input ack_error, input ack_parity,
                      input ack_parity_bad, input ack_valid,
                      input ext_irq_pin);
   modport target (input link_clock, input link_data,
                   output ack_data, output ack_error, output ack_parity,
                   output ack_parity_bad, output ack_valid,
                   output ext_irq_pin);
endinterface
`default_nettype wire

// *** link_initiator.sv ***
// Initiator end: APB registers, link clock divider, frame sender, faults.
// Assumes the target answers within the programmed wait limit.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module link_initiator
   import link_pkg::*;
(
   // System.
   input  wire logic        MCLK,
   input  wire logic        RST,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Interrupt requests.
   output logic             EXT_IRQ,
   output logic             FAULT_IRQ,
   // Link.
   link_if.initiator        link
);
   typedef enum {S_IDLE, S_ARM, S_SEND, S_WAIT} phase_e;
   typedef struct packed {
      logic        irq_en;
      logic [3:0]  wait_limit;
      logic        enabled;
      logic        special;
      logic [7:0]  fault;
      logic [15:0] addr_buf;
      logic        busy;
      phase_e      phase;
      logic [3:0]  div_cnt;
      logic        lclk;
      logic [4:0]  bit_cnt;
      logic [16:0] shift;
      logic        data_out;
      logic [4:0]  wait_cnt;
      logic [1:0]  ack_s0, ack_s1;
      logic [1:0]  irq_s;
      logic        ack_prev;
      logic [31:0] prdata;
      logic        pready;
      logic        ext_irq;
      logic        fault_irq;
   } state_s;
   state_s s, next_s;
   logic   ack_now;
   // True in the cycle in which the link clock is about to fall.
   function automatic logic link_fall(input logic [3:0] cnt,
                                      input logic       lvl);
      return (cnt == CLK_DIV_HALF - 4'h1) && lvl;
   endfunction
   always_comb begin
      next_s = s;
      next_s.ack_s0 = {link.ack_valid, link.ext_irq_pin};
      next_s.ack_s1 = s.ack_s0;
      next_s.irq_s  = {s.irq_s[0], s.ack_s1[0]};
      next_s.ack_prev = s.ack_s1[1];
      ack_now = s.ack_s1[1] && !s.ack_prev;
      next_s.pready = PSEL && !PENABLE;
      next_s.prdata = 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            OFS_CONTROL:  next_s.prdata = {24'h0, s.irq_en, 3'h0, s.wait_limit};
            OFS_FAULT:    next_s.prdata = {24'h0, s.fault};
            OFS_IRQ_BUSY: next_s.prdata = {24'h0, s.irq_s[1], s.busy, 6'h0};
            OFS_ADDRESS:  next_s.prdata = {16'h0, s.addr_buf};
            OFS_MODE:     next_s.prdata = {30'h0, s.special, s.enabled};
            default:      next_s.prdata = 32'h0000_0000;
         endcase
      end
      if (PSEL && PENABLE && s.pready && PWRITE) begin
         case (PADDR)
            OFS_CONTROL: begin
               next_s.irq_en = PWDATA[BIT_IRQ_EN];
               if (!s.enabled || s.special) begin
                  next_s.wait_limit = PWDATA[3:0];
               end
            end
            OFS_FAULT: begin
               if (PWDATA[BIT_SUMMARY]) begin
                  next_s.fault = FAULT_RESET;
               end
            end
            OFS_MODE: begin
               next_s.enabled = s.enabled | PWDATA[0];
               next_s.special = PWDATA[1];
            end
            OFS_REQUEST: begin
               if (s.fault[BIT_SUMMARY]) begin
                  next_s.fault[BIT_CANCEL] = 1'b1;
               end else if (s.enabled && !s.busy) begin
                  next_s.addr_buf = PWDATA[15:0];
                  next_s.busy     = 1'b1;
                  next_s.phase    = S_ARM;
               end
            end
            default: ;
         endcase
      end
      if (s.enabled) begin
         next_s.div_cnt = s.div_cnt + 4'h1;
         if (s.div_cnt == CLK_DIV_HALF - 4'h1) begin
            next_s.div_cnt = 4'h0;
            next_s.lclk    = !s.lclk;
         end
      end
      case (s.phase)
         S_IDLE: ;
         S_ARM: begin
            // A leading high start bit lets the far end find the frame.
            if (link_fall(s.div_cnt, s.lclk)) begin
               next_s.shift   = {1'b1, s.addr_buf};
               next_s.bit_cnt = 5'(FRAME_BITS + 1);
               next_s.phase   = S_SEND;
            end
         end
         S_SEND: begin
            if (link_fall(s.div_cnt, s.lclk)) begin
               next_s.shift   = {s.shift[15:0], 1'b0};
               next_s.bit_cnt = s.bit_cnt - 5'h1;
               if (s.bit_cnt == 5'h1) begin
                  next_s.phase    = S_WAIT;
                  next_s.wait_cnt = 5'h0;
               end
            end
         end
         S_WAIT: begin
            if (ack_now) begin
               next_s.busy  = 1'b0;
               next_s.phase = S_IDLE;
               if (link.ack_data != 8'hFF) begin
                  next_s.fault[BIT_ACK_LEVEL] = 1'b1;
               end
               if (link.ack_error) begin
                  next_s.fault[BIT_TARGET] = 1'b1;
               end
               if (link.ack_parity_bad) begin
                  next_s.fault[BIT_PARITY] = 1'b1;
                  next_s.fault[1:0] = link.ack_parity;
               end
            end else if (link_fall(s.div_cnt, s.lclk)) begin
               next_s.wait_cnt = s.wait_cnt + 5'h1;
               if (s.wait_cnt >= {1'b0, s.wait_limit}) begin
                  next_s.fault[BIT_TIMEOUT] = 1'b1;
                  next_s.busy  = 1'b0;
                  next_s.phase = S_IDLE;
               end
            end
         end
         default: next_s.phase = S_IDLE;
      endcase
      next_s.data_out = (next_s.phase == S_SEND) && next_s.shift[16];
      if (|next_s.fault[6:2]) begin
         next_s.fault[BIT_SUMMARY] = 1'b1;
      end
      next_s.ext_irq   = s.irq_en && s.irq_s[1];
      next_s.fault_irq = s.fault[BIT_SUMMARY];
      if (RST) begin
         next_s = '0;
      end
   end
   always_ff @(posedge MCLK) begin
      s <= next_s;
   end
   assign link.link_clock = s.lclk;
   assign link.link_data  = s.data_out;
   assign PRDATA    = s.prdata;
   assign PREADY    = s.pready;
   assign PSLVERR   = 1'b0;
   assign EXT_IRQ   = s.ext_irq;
   assign FAULT_IRQ = s.fault_irq;
endmodule
`default_nettype wire

// *** link_target.sv ***
// Target end: receives frames on the link clock and answers with an ack.
// Assumes the link clock is slow against MCLK and comes from the initiator.
`timescale 1ns/1ps
`default_nettype none
module link_target
   import link_pkg::*;
(
   // System.
   input  wire logic        MCLK,
   input  wire logic        RST,
   // User side.
   input  wire logic [3:0]  ACK_DELAY,
   input  wire logic        ANSWER_ERROR,
   input  wire logic        IRQ_REQUEST,
   output logic      [15:0] RX_WORD,
   output logic             RX_STROBE,
   // Link.
   link_if.target           link
);
   typedef enum {T_RECV, T_DELAY, T_ACK} phase_e;
   typedef struct packed {
      logic [1:0]  clk_s;
      logic [1:0]  dat_s;
      logic        clk_prev;
      logic [4:0]  bit_cnt;
      logic [15:0] shift;
      logic [3:0]  delay;
      logic        ack;
      logic [15:0] rx_word;
      logic        rx_strobe;
      phase_e      phase;
      logic        irq;
      logic        err;
      logic [1:0]  parity;
   } state_s;
   state_s s, next_s;
   logic   rise;
   always_comb begin
      next_s = s;
      next_s.clk_s = {s.clk_s[0], link.link_clock};
      next_s.dat_s = {s.dat_s[0], link.link_data};
      next_s.clk_prev = s.clk_s[1];
      rise = s.clk_s[1] && !s.clk_prev;
      next_s.rx_strobe = 1'b0;
      next_s.irq = IRQ_REQUEST;
      next_s.err = ANSWER_ERROR;
      next_s.parity = ^s.shift ? 2'h1 : 2'h2;
      case (s.phase)
         T_RECV: begin
            // A high bit on the idle line marks the start of a frame.
            if (rise && s.bit_cnt == 5'h0) begin
               if (s.dat_s[1]) begin
                  next_s.bit_cnt = 5'h1;
               end
            end else if (rise) begin
               next_s.shift   = {s.shift[14:0], s.dat_s[1]};
               next_s.bit_cnt = s.bit_cnt + 5'h1;
               if (s.bit_cnt == 5'(FRAME_BITS)) begin
                  next_s.bit_cnt = 5'h0;
                  next_s.delay   = ACK_DELAY;
                  next_s.phase   = T_DELAY;
               end
            end
         end
         T_DELAY: begin
            if (s.delay == 4'h0) begin
               next_s.ack       = 1'b1;
               next_s.rx_word   = s.shift;
               next_s.rx_strobe = 1'b1;
               next_s.phase     = T_ACK;
            end else if (rise) begin
               next_s.delay = s.delay - 4'h1;
            end
         end
         T_ACK: begin
            if (rise) begin
               next_s.ack   = 1'b0;
               next_s.phase = T_RECV;
            end
         end
         default: next_s.phase = T_RECV;
      endcase
      if (RST) begin
         next_s = '0;
      end
   end
   always_ff @(posedge MCLK) begin
      s <= next_s;
   end
   assign link.ack_valid      = s.ack;
   assign link.ack_data       = 8'hFF;
   assign link.ack_error      = s.err;
   assign link.ack_parity     = s.parity;
   assign link.ack_parity_bad = 1'b0;
   assign link.ext_irq_pin    = s.irq;
   assign RX_WORD   = s.rx_word;
   assign RX_STROBE = s.rx_strobe;
endmodule
`default_nettype wire

// *** link_monitor.sv ***
// Checker: APB handshake, interrupt outputs and link lines.
// Assumes the bench ties it to the initiator ports and the interface.
`timescale 1ns/1ps
`default_nettype none
module link_monitor
   import link_pkg::*;
(
   // Watched signals.
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        EXT_IRQ,
   input wire logic        FAULT_IRQ,
   input wire logic        link_clock,
   input wire logic [7:0]  ack_data,
   input wire logic        ack_valid,
   input wire logic        ext_irq_pin
);
   logic clr;
   assign clr = PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_FAULT
                && PWDATA[BIT_SUMMARY];
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   a_reset_quiet:
      assert property ($fell(RST) |-> !EXT_IRQ && !FAULT_IRQ && !ack_valid)
         else $error("output up after reset");
   a_ack_high:
      assert property (ack_valid |-> ack_data == 8'hFF) else $error("ack low");
   a_irq_gate:
      assert property ((!ext_irq_pin) [*5] |=> !EXT_IRQ) else $error("irq");
   a_irq_cause:
      assert property ($rose(EXT_IRQ) |-> $past(ext_irq_pin, 5))
         else $error("irq rose, pin low");
   a_fault_drop:
      assert property ($fell(FAULT_IRQ) |-> $past(clr) || $past(clr, 2)
                       || $past(RST)) else $error("fault lost");
   a_fault_clear:
      assert property (clr && !ack_valid |-> ##[1:2] !FAULT_IRQ)
         else $error("fault kept");
   a_clk_high:
      assert property ($rose(link_clock) |=> link_clock [*3] ##1 !link_clock)
         else $error("link clock shape");
   a_ready_once:
      assert property (PSEL && PENABLE |-> PREADY ##1 !PREADY)
         else $error("ready shape");
endmodule
`default_nettype wire

// *** die_link_status_ctrl_tb_top.sv ***
// Bench: both link ends joined over the interface, driven through APB.
// Assumes the target acks after the wait states set on its user side.
`timescale 1ns/1ps
`default_nettype none
module die_link_status_ctrl_tb_top
   import link_pkg::*;
;
   logic        MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
   logic        PWRITE = 1'b0, ANSWER_ERROR = 1'b0, IRQ_REQUEST = 1'b0;
   logic        PREADY, EXT_IRQ, FAULT_IRQ, RX_STROBE;
   logic [3:0]  ACK_DELAY = 4'h0;
   logic [7:0]  PADDR = 8'h00;
   logic [15:0] RX_WORD, rx_last;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd, adr0 = 32'hFFFFFFFF;
   int          error_cnt = 0, checks = 0;
   link_if lk ();
   link_initiator i_link_initiator (.MCLK, .RST, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR(), .EXT_IRQ, .FAULT_IRQ,
      .link(lk));
   link_target i_link_target (.MCLK, .RST, .ACK_DELAY, .ANSWER_ERROR,
      .IRQ_REQUEST, .RX_WORD, .RX_STROBE, .link(lk));
   link_monitor i_link_monitor (.MCLK, .RST, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PREADY, .EXT_IRQ, .FAULT_IRQ, .ack_data(lk.ack_data),
      .link_clock(lk.link_clock), .ack_valid(lk.ack_valid),
      .ext_irq_pin(lk.ext_irq_pin));
   initial forever #25 MCLK = ~MCLK;
   always @(posedge MCLK) if (RX_STROBE === 1'b1) rx_last <= RX_WORD;
   task automatic chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) error_cnt++;
      if (seen !== exp) $display("unexpected %0t: %h, not %h", $time, seen, exp);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      @(posedge MCLK);
      while (PREADY !== 1'b1) @(posedge MCLK);
      rd = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      for (int n = 0; n < 300 && (rd & m) !== e; n++) apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #1000000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge MCLK);
      RST <= 1'b0;
      for (int i = 0; i < 3; i++) rdc(8'(4 * i), 32'hFF, 32'h0);
      rdc(8'h1C, 32'hFFFFFFFF, 32'h0);
      IRQ_REQUEST <= 1'b1;
      poll(OFS_IRQ_BUSY, 32'h80, 32'h80);
      chk(32'(EXT_IRQ), 32'h0);
      apb(1'b1, OFS_CONTROL, 32'h83);
      apb(1'b1, OFS_MODE, 32'h1);
      apb(1'b1, OFS_CONTROL, 32'h8F);
      rdc(OFS_CONTROL, 32'hFF, 32'h83);
      apb(1'b1, OFS_MODE, 32'h3);
      apb(1'b1, OFS_CONTROL, 32'h85);
      rdc(OFS_CONTROL, 32'hFF, 32'h85);
      apb(1'b1, OFS_CONTROL, 32'h83);
      apb(1'b1, OFS_MODE, 32'h1);
      chk(32'(EXT_IRQ), 32'h1);
      apb(1'b1, OFS_IRQ_BUSY, 32'h0);
      rdc(OFS_IRQ_BUSY, 32'hC0, 32'h80);
      $display("setup test done");
      for (int d = 0; d < 5; d++) begin
         ACK_DELAY <= 4'(d);
         apb(1'b1, OFS_REQUEST, {16'h0, 4'(d), 12'h5A3});
         rdc(OFS_IRQ_BUSY, 32'h40, 32'h40);
         poll(OFS_IRQ_BUSY, 32'h40, 32'h0);
         rdc(OFS_FAULT, 32'hFF, d < 4 ? 32'h0 : 32'h90);
         chk({16'h0, rx_last}, {16'h0, 4'(d), 12'h5A3});
         rdc(OFS_ADDRESS, 32'hFFFF, {16'h0, 4'(d), 12'h5A3});
         adr0 = rd;
      end
      chk(32'(FAULT_IRQ), 32'h1);
      $display("wait limit test done");
      apb(1'b1, OFS_REQUEST, 32'h0F0F);
      poll(OFS_IRQ_BUSY, 32'h40, 32'h0);
      rdc(OFS_FAULT, 32'hFF, 32'hB0);
      rdc(OFS_ADDRESS, 32'hFFFFFFFF, adr0);
      apb(1'b1, OFS_FAULT, 32'h7F);
      rdc(OFS_FAULT, 32'hFF, 32'hB0);
      apb(1'b1, OFS_FAULT, 32'h80);
      rdc(OFS_FAULT, 32'hFF, 32'h0);
      $display("cancel test done");
      ACK_DELAY <= 4'h0;
      ANSWER_ERROR <= 1'b1;
      apb(1'b1, OFS_REQUEST, 32'h3C3C);
      poll(OFS_IRQ_BUSY, 32'h40, 32'h0);
      rdc(OFS_FAULT, 32'hFF, 32'h88);
      $display("target error test done");
      IRQ_REQUEST <= 1'b0;
      poll(OFS_IRQ_BUSY, 32'h80, 32'h0);
      chk(32'(EXT_IRQ), 32'h0);
      $display("interrupt drop test done");
      conclude();
   end
endmodule
`default_nettype wire
